// [core/framer_pkg.sv]
// constants shared by the output framer: register map, field positions,
// reset values and framing encodings.
// assumes a 9-bit serial register address and 10-bit pixel words.
package framer_pkg;
    localparam int ADDR_W = 9;
    localparam int REG_W = 16;
    localparam int PIX_W = 10;
    localparam int NUM_RW_REGS = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int SPI_HDR_LAST = 9;
    localparam int SPI_FRAME_LAST = 25;
    localparam int ACC_W = 17;
    // register offsets
    localparam logic [ADDR_W-1:0] DARK_CAL_CONFIG_ADDR = 9'h080;
    localparam logic [ADDR_W-1:0] OUTPUT_GENERAL_CONFIG_ADDR = 9'h081;
    localparam logic [ADDR_W-1:0] IDLE_ALIGN_PATTERN_ADDR = 9'h082;
    localparam logic [ADDR_W-1:0] FRAME_ROW_MARKER_CODE_ADDR = 9'h083;
    localparam logic [ADDR_W-1:0] DARK_PIXEL_MARKER_CODE_ADDR = 9'h084;
    localparam logic [ADDR_W-1:0] VALID_PIXEL_MARKER_CODE_ADDR = 9'h085;
    localparam logic [ADDR_W-1:0] CHECKSUM_MARKER_CODE_ADDR = 9'h086;
    localparam logic [ADDR_W-1:0] ALIGN_WORD_MARKER_CODE_ADDR = 9'h087;
    localparam logic [ADDR_W-1:0] DARK_LEVEL_ERROR_STATUS_ADDR = 9'h088;
    // register indices, relative to the first offset
    localparam int IDX_CAL = 0;
    localparam int IDX_GEN = 1;
    localparam int IDX_TRAIN = 2;
    localparam int IDX_MARK = 3;
    localparam int IDX_DARK = 4;
    localparam int IDX_VALID = 5;
    localparam int IDX_CSUM = 6;
    localparam int IDX_ALIGN = 7;
    localparam logic [REG_W-1:0] REG_RESET [NUM_RW_REGS] = '{
        16'h4008, 16'hc001, 16'h03a6, 16'h002a, 16'h0015, 16'h0035, 16'h0059, 16'h03a6};
    // field positions
    localparam int TARGET_LSB = 0;
    localparam int SAMPLES_LSB = 8;
    localparam int SEED_BIT = 15;
    localparam int AUTO_BIT = 0;
    localparam int OFFSET_LSB = 1;
    localparam int DEC_BIT = 10;
    localparam int NARROW_BIT = 13;
    localparam int FRAME_ON_BIT = 14;
    localparam int ROW_ON_BIT = 15;
    // row checksum polynomial
    localparam logic [PIX_W-1:0] CSUM_POLY = 10'h233;
    typedef enum logic [1:0] {ST_IDLE, ST_PIX, ST_END, ST_CSUM} frame_state_t;
endpackage

// [core/pixel_output_sync_framer.sv]
// output framer: register port, dark-level correction, row framing with
// sync codes and checksum, clock-crossing fifo and the link-side lanes.
// assumes the pixel stream runs on i_clock; the lanes run on i_link_clock.
`timescale 1ns/10ps

module cdc_word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // write side
    input wire logic i_wr_clock,
    input wire logic i_wr_nrst,
    input wire logic i_wr_valid,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_wr_ready,
    // read side
    input wire logic i_rd_clock,
    input wire logic i_rd_nrst,
    input wire logic i_rd_ready,
    output logic o_rd_valid,
    output logic [WIDTH-1:0] o_rd_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 4 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_depth
        $error("fifo depth must be a power of two of at least 4");
    end
    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wbin_reg, wgray_reg, rbin_reg, rgray_reg;
    logic [AW:0] rg_s1_reg, rg_s2_reg, wg_s1_reg, wg_s2_reg;
    logic [AW:0] wbin_next, rbin_next;
    logic do_wr, do_rd;
    assign do_wr = i_wr_valid & o_wr_ready;
    assign do_rd = o_rd_valid & i_rd_ready;
    assign wbin_next = wbin_reg + (AW+1)'(do_wr);
    assign rbin_next = rbin_reg + (AW+1)'(do_rd);
    assign o_rd_data = mem[rbin_reg[AW-1:0]];
    always_ff @(posedge i_wr_clock) begin
        if (do_wr)
            mem[wbin_reg[AW-1:0]] <= i_wr_data;
    end
    // only gray-coded pointers cross; full and empty are pessimistic
    always_ff @(posedge i_wr_clock) begin
        if (!i_wr_nrst) begin
            wbin_reg <= '0;
            wgray_reg <= '0;
            rg_s1_reg <= '0;
            rg_s2_reg <= '0;
            o_wr_ready <= 1'b0;
        end else begin
            wbin_reg <= wbin_next;
            wgray_reg <= to_gray(wbin_next);
            rg_s1_reg <= rgray_reg;
            rg_s2_reg <= rg_s1_reg;
            o_wr_ready <= to_gray(wbin_next) != {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]};
        end
    end
    always_ff @(posedge i_rd_clock) begin
        if (!i_rd_nrst) begin
            rbin_reg <= '0;
            rgray_reg <= '0;
            wg_s1_reg <= '0;
            wg_s2_reg <= '0;
            o_rd_valid <= 1'b0;
        end else begin
            rbin_reg <= rbin_next;
            rgray_reg <= to_gray(rbin_next);
            wg_s1_reg <= wgray_reg;
            wg_s2_reg <= wg_s1_reg;
            o_rd_valid <= to_gray(rbin_next) != wg_s2_reg;
        end
    end
endmodule

module pixel_output_sync_framer import framer_pkg::*; #(
    parameter int LANES = 4
) (
    // clocks and resets
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_link_clock,
    input wire logic i_link_nrst,
    // serial register port
    input wire logic i_spi_sck,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    // pixel stream from readout
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [LANES*PIX_W-1:0] i_in_data,
    input wire logic i_in_first,
    input wire logic i_in_last,
    input wire logic i_in_dark,
    input wire logic i_in_frame_start,
    input wire logic i_in_frame_end,
    // output lanes
    output logic [LANES*PIX_W-1:0] o_lane_data,
    output logic [PIX_W-1:0] o_sync_lane,
    output logic o_frame_flag,
    output logic o_row_flag
);
    localparam int FW = 2 + PIX_W + LANES*PIX_W;
    if (LANES < 1 || LANES > 8) begin : g_bad_lanes
        $error("lane count must be 1 to 8");
    end

    // serial register port, oversampled on i_clock
    logic sck_s1_reg, sck_s2_reg, sck_d_reg, cs_s1_reg, cs_s2_reg, mosi_s1_reg, mosi_s2_reg;
    logic [4:0] bit_cnt_reg;
    logic [23:0] shift_reg;
    logic [REG_W-1:0] rd_shift_reg;
    logic [ADDR_W-1:0] spi_addr_reg;
    logic spi_wr_reg;
    logic [REG_W-1:0] regs_reg [NUM_RW_REGS];
    logic [LANES-1:0] err_reg;
    logic sck_rise, sck_fall;
    assign sck_rise = sck_s2_reg & ~sck_d_reg;
    assign sck_fall = ~sck_s2_reg & sck_d_reg;

    function automatic logic [REG_W-1:0] read_value(input logic [ADDR_W-1:0] a);
        if (a >= DARK_CAL_CONFIG_ADDR && a <= ALIGN_WORD_MARKER_CODE_ADDR)
            return regs_reg[3'(a - DARK_CAL_CONFIG_ADDR)];
        else if (a == DARK_LEVEL_ERROR_STATUS_ADDR)
            return REG_W'(err_reg);
        else
            return '0;
    endfunction

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            {sck_s1_reg, sck_s2_reg, sck_d_reg} <= '0;
            {cs_s1_reg, cs_s2_reg} <= 2'h3;
            {mosi_s1_reg, mosi_s2_reg} <= '0;
        end else begin
            sck_s1_reg <= i_spi_sck;
            sck_s2_reg <= sck_s1_reg;
            sck_d_reg <= sck_s2_reg;
            cs_s1_reg <= i_spi_cs_n;
            cs_s2_reg <= cs_s1_reg;
            mosi_s1_reg <= i_spi_mosi;
            mosi_s2_reg <= mosi_s1_reg;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst || cs_s2_reg) begin
            bit_cnt_reg <= '0;
            shift_reg <= '0;
        end else if (sck_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            shift_reg <= {shift_reg[22:0], mosi_s2_reg};
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            spi_addr_reg <= '0;
            spi_wr_reg <= 1'b0;
            rd_shift_reg <= '0;
            o_spi_miso <= 1'b0;
        end else if (!cs_s2_reg && sck_rise && bit_cnt_reg == 5'(SPI_HDR_LAST)) begin
            spi_addr_reg <= shift_reg[ADDR_W-1:0];
            spi_wr_reg <= mosi_s2_reg;
            rd_shift_reg <= read_value(shift_reg[ADDR_W-1:0]);
        end else if (!cs_s2_reg && sck_fall && !spi_wr_reg && bit_cnt_reg > 5'(SPI_HDR_LAST)) begin
            o_spi_miso <= rd_shift_reg[REG_W-1];
            rd_shift_reg <= {rd_shift_reg[REG_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            regs_reg <= REG_RESET;
        end else if (!cs_s2_reg && sck_rise && spi_wr_reg && bit_cnt_reg == 5'(SPI_FRAME_LAST)
                     && spi_addr_reg >= DARK_CAL_CONFIG_ADDR && spi_addr_reg <= ALIGN_WORD_MARKER_CODE_ADDR) begin
            regs_reg[3'(spi_addr_reg - DARK_CAL_CONFIG_ADDR)] <= {shift_reg[REG_W-2:0], mosi_s2_reg};
        end
    end

    // configuration fields
    logic seed_one, auto_en, dec, narrow, frame_on, row_on;
    logic [8:0] offset;
    logic [7:0] target;
    logic [2:0] samples;
    assign target = regs_reg[IDX_CAL][TARGET_LSB +: 8];
    assign samples = regs_reg[IDX_CAL][SAMPLES_LSB +: 3];
    assign seed_one = regs_reg[IDX_CAL][SEED_BIT];
    assign auto_en = regs_reg[IDX_GEN][AUTO_BIT];
    assign offset = regs_reg[IDX_GEN][OFFSET_LSB +: 9];
    assign dec = regs_reg[IDX_GEN][DEC_BIT];
    assign narrow = regs_reg[IDX_GEN][NARROW_BIT];
    assign frame_on = regs_reg[IDX_GEN][FRAME_ON_BIT];
    assign row_on = regs_reg[IDX_GEN][ROW_ON_BIT];

    // one-word holding stage keeps o_in_ready a flip-flop
    logic hold_valid_reg, hold_first_reg, hold_last_reg, hold_dark_reg, hold_fs_reg, hold_fe_reg;
    logic [LANES*PIX_W-1:0] hold_data_reg;
    logic take, consume, push, hold_valid_next;
    frame_state_t state_reg;
    assign take = i_in_valid & o_in_ready;
    assign hold_valid_next = (hold_valid_reg & ~consume) | take;

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            hold_valid_reg <= 1'b0;
            o_in_ready <= 1'b0;
            {hold_first_reg, hold_last_reg, hold_dark_reg, hold_fs_reg, hold_fe_reg} <= '0;
            hold_data_reg <= '0;
        end else begin
            hold_valid_reg <= hold_valid_next;
            o_in_ready <= ~hold_valid_next;
            if (take) begin
                hold_data_reg <= i_in_data;
                {hold_first_reg, hold_last_reg, hold_dark_reg} <= {i_in_first, i_in_last, i_in_dark};
                {hold_fs_reg, hold_fe_reg} <= {i_in_frame_start, i_in_frame_end};
            end
        end
    end

    // dark-level correction, checksum and calibration per lane
    logic [LANES*PIX_W-1:0] out_vec, csum_vec;
    logic signed [10:0] manual_corr;
    logic [7:0] cnt_reg;
    logic [8:0] need;
    logic cal_step, cal_done, done_row_reg, row_dark_reg, row_fe_reg, frame_act_reg;
    logic fifo_ready;
    assign manual_corr = dec ? -$signed({2'b00, offset}) : $signed({2'b00, offset});
    assign need = 9'h001 << samples;
    assign cal_step = consume & hold_dark_reg & auto_en;
    assign cal_done = cal_step && ({1'b0, cnt_reg} + 9'h001 == need);

    function automatic logic [PIX_W-1:0] csum_step(input logic [PIX_W-1:0] c, input logic [PIX_W-1:0] d);
        logic [PIX_W-1:0] r;
        logic fb;
        r = c;
        for (int i = PIX_W-1; i >= 0; i--) begin
            fb = r[PIX_W-1] ^ d[i];
            r = {r[PIX_W-2:0], 1'b0} ^ (fb ? CSUM_POLY : 10'h000);
        end
        return r;
    endfunction

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [PIX_W-1:0] raw, clamped, avg, csum_reg;
        logic signed [10:0] corr, auto_corr_reg;
        logic signed [11:0] sum;
        logic [ACC_W-1:0] acc_reg;
        assign raw = hold_data_reg[l*PIX_W +: PIX_W];
        assign corr = auto_en ? auto_corr_reg : manual_corr;
        assign sum = $signed({2'b00, raw}) + 12'(corr);
        assign clamped = sum[11] ? 10'h000 : (sum[10] ? 10'h3ff : sum[9:0]);
        assign out_vec[l*PIX_W +: PIX_W] = narrow ? {2'b00, clamped[9:2]} : clamped;
        assign avg = PIX_W'((acc_reg + ACC_W'(raw)) >> samples);
        assign csum_vec[l*PIX_W +: PIX_W] = csum_reg;
        always_ff @(posedge i_clock) begin
            if (!i_nrst) begin
                acc_reg <= '0;
                auto_corr_reg <= '0;
            end else if (cal_done) begin
                acc_reg <= '0;
                auto_corr_reg <= 11'($signed({3'b000, target}) - $signed({1'b0, avg}));
            end else if (cal_step) begin
                acc_reg <= acc_reg + ACC_W'(raw);
            end
        end
        always_ff @(posedge i_clock) begin
            if (!i_nrst)
                csum_reg <= '0;
            else if (push && state_reg == ST_IDLE)
                csum_reg <= seed_one ? 10'h3ff : 10'h000;
            else if (consume)
                csum_reg <= csum_step(csum_reg, out_vec[l*PIX_W +: PIX_W]);
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            cnt_reg <= '0;
            done_row_reg <= 1'b0;
            err_reg <= '0;
        end else begin
            if (cal_done)
                cnt_reg <= '0;
            else if (cal_step)
                cnt_reg <= cnt_reg + 8'h01;
            if (push && state_reg == ST_IDLE)
                done_row_reg <= 1'b0;
            else if (cal_done)
                done_row_reg <= 1'b1;
            // a short dark row flags every lane; a completed average clears it
            if (push && state_reg == ST_END && row_dark_reg && auto_en && !done_row_reg)
                err_reg <= '1;
            else if (cal_done)
                err_reg <= '0;
        end
    end

    // row framing
    function automatic logic [PIX_W-1:0] marker(input logic f, input logic s, input logic e);
        return {f, s, e, regs_reg[IDX_MARK][6:0]};
    endfunction
    logic w_valid, w_frame, w_row;
    logic [PIX_W-1:0] w_sync;
    logic [LANES*PIX_W-1:0] w_data;
    logic w_dark;
    assign w_dark = state_reg == ST_IDLE ? hold_dark_reg : row_dark_reg;

    always_comb begin
        w_valid = 1'b1;
        w_data = '0;
        w_row = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                w_valid = hold_valid_reg;
                w_sync = marker(hold_fs_reg, 1'b1, 1'b0);
            end
            ST_PIX: begin
                w_valid = hold_valid_reg;
                w_sync = hold_dark_reg ? regs_reg[IDX_DARK][9:0] : regs_reg[IDX_VALID][9:0];
                w_data = out_vec;
                w_row = ~hold_dark_reg | row_on;
            end
            ST_END: w_sync = marker(row_fe_reg, 1'b0, 1'b1);
            ST_CSUM: begin
                w_sync = regs_reg[IDX_CSUM][9:0];
                w_data = csum_vec;
            end
            default: w_sync = '0;
        endcase
        w_frame = ((state_reg == ST_IDLE && hold_fs_reg) | frame_act_reg) & (~w_dark | frame_on);
    end
    assign push = w_valid & fifo_ready;
    assign consume = push & (state_reg == ST_PIX);

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            state_reg <= ST_IDLE;
            row_dark_reg <= 1'b0;
            row_fe_reg <= 1'b0;
            frame_act_reg <= 1'b0;
        end else if (push) begin
            case (state_reg)
                ST_IDLE: begin
                    state_reg <= ST_PIX;
                    row_dark_reg <= hold_dark_reg;
                    row_fe_reg <= hold_fe_reg;
                    if (hold_fs_reg)
                        frame_act_reg <= 1'b1;
                end
                ST_PIX: if (hold_last_reg) state_reg <= ST_END;
                ST_END: begin
                    state_reg <= ST_CSUM;
                    if (row_fe_reg)
                        frame_act_reg <= 1'b0;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // fifo carries framed words into the link domain
    logic rd_valid, run_reg;
    logic [FW-1:0] rd_data;
    cdc_word_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_wr_clock(i_clock),
        .i_wr_nrst(i_nrst),
        .i_wr_valid(w_valid),
        .i_wr_data({w_frame, w_row, w_sync, w_data}),
        .o_wr_ready(fifo_ready),
        .i_rd_clock(i_link_clock),
        .i_rd_nrst(i_link_nrst),
        .i_rd_ready(run_reg),
        .o_rd_valid(rd_valid),
        .o_rd_data(rd_data)
    );

    // idle words cross by toggle handshake; snapshot holds until acknowledged
    logic [2*PIX_W-1:0] snap_reg, link_cfg_reg;
    logic req_reg, ack_reg, ack_s1_reg, ack_s2_reg, req_s1_reg, req_s2_reg;
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            snap_reg <= {REG_RESET[IDX_ALIGN][9:0], REG_RESET[IDX_TRAIN][9:0]};
            req_reg <= 1'b0;
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end else begin
            ack_s1_reg <= ack_reg;
            ack_s2_reg <= ack_s1_reg;
            if (req_reg == ack_s2_reg && snap_reg != {regs_reg[IDX_ALIGN][9:0], regs_reg[IDX_TRAIN][9:0]}) begin
                snap_reg <= {regs_reg[IDX_ALIGN][9:0], regs_reg[IDX_TRAIN][9:0]};
                req_reg <= ~req_reg;
            end
        end
    end

    always_ff @(posedge i_link_clock) begin
        if (!i_link_nrst) begin
            link_cfg_reg <= {REG_RESET[IDX_ALIGN][9:0], REG_RESET[IDX_TRAIN][9:0]};
            {req_s1_reg, req_s2_reg, ack_reg} <= '0;
        end else begin
            req_s1_reg <= req_reg;
            req_s2_reg <= req_s1_reg;
            ack_reg <= req_s2_reg;
            if (req_s2_reg != ack_reg)
                link_cfg_reg <= snap_reg;
        end
    end

    always_ff @(posedge i_link_clock) begin
        if (!i_link_nrst) begin
            run_reg <= 1'b0;
            {o_frame_flag, o_row_flag} <= '0;
            o_sync_lane <= '0;
            o_lane_data <= '0;
        end else begin
            run_reg <= 1'b1;
            if (rd_valid && run_reg) begin
                {o_frame_flag, o_row_flag, o_sync_lane, o_lane_data} <= rd_data;
            end else begin
                {o_frame_flag, o_row_flag} <= '0;
                o_sync_lane <= link_cfg_reg[2*PIX_W-1:PIX_W];
                o_lane_data <= {LANES{link_cfg_reg[PIX_W-1:0]}};
            end
        end
    end

    // checks
    csum_seed_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (push && state_reg == ST_IDLE) |=> g_lane[0].csum_reg == {PIX_W{seed_one}})
        else $error("checksum not seeded");
    manual_off_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (consume && !auto_en && !narrow && !dec && ({1'b0, g_lane[0].raw} + {2'b00, offset}) < 11'h400)
        |-> w_data[9:0] == g_lane[0].raw + offset)
        else $error("manual offset not added");
    narrow_word_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (consume && narrow) |-> w_data[9:8] == 2'b00 && w_data[7:0] == g_lane[0].clamped[9:2])
        else $error("narrow word wrong");
    frame_gate_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (push && state_reg != ST_IDLE && row_dark_reg && !frame_on) |-> !w_frame)
        else $error("frame flag in dark row");
    row_gate_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (consume && hold_dark_reg && !row_on) |-> !w_row)
        else $error("row flag in dark row");
    idle_train_a: assert property (@(posedge i_link_clock) disable iff (!i_link_nrst)
        (run_reg && !rd_valid) |=> o_lane_data[PIX_W-1:0] == $past(link_cfg_reg[PIX_W-1:0])
        && o_sync_lane == $past(link_cfg_reg[2*PIX_W-1:PIX_W]))
        else $error("idle word wrong");
    start_mark_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (push && state_reg == ST_IDLE) |-> w_sync == {hold_fs_reg, 2'b10, regs_reg[IDX_MARK][6:0]}
        ##1 state_reg == ST_PIX)
        else $error("start marker wrong");
    pix_code_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        consume |-> w_sync == (hold_dark_reg ? regs_reg[IDX_DARK][9:0] : regs_reg[IDX_VALID][9:0]))
        else $error("pixel code wrong");
    csum_word_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (push && state_reg == ST_END) |=> state_reg == ST_CSUM && w_sync == regs_reg[IDX_CSUM][9:0]
        && w_data[9:0] == g_lane[0].csum_reg)
        else $error("checksum word wrong");
    cal_err_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (push && state_reg == ST_END && row_dark_reg && auto_en && !done_row_reg) |=> err_reg[0])
        else $error("calibration error not flagged");
endmodule

// [testbench/lane_receiver.sv]
// receiver model: finds word alignment on the idle training word
// assumes registered lanes on the link clock
`timescale 1ns/10ps
module lane_receiver import framer_pkg::*; #(parameter int LANES = 4) (
    input wire logic i_link_clock,
    input wire logic i_link_nrst,
    input wire logic [LANES*PIX_W-1:0] i_lane_data,
    input wire logic [PIX_W-1:0] i_sync_lane,
    output logic o_locked,
    output logic o_busy
);
    always_ff @(posedge i_link_clock) begin
        if (!i_link_nrst) o_locked <= 1'b0;
        else if (i_lane_data === {LANES{10'h3a6}}) o_locked <= 1'b1;
    end
    // words are only interpreted once aligned
    assign o_busy = o_locked && (i_sync_lane !== 10'h3a6);
endmodule

// [testbench/pixel_output_sync_framer_tb.sv]
// self-checking bench for the output framer
// assumes the lane receiver model on the link side
`timescale 1ns/10ps
module pixel_output_sync_framer_tb import framer_pkg::*;;
    logic i_clock = 0, i_link_clock = 0, i_nrst = 0, i_link_nrst = 0, sck = 0, cs_n = 1, mosi = 0;
    logic in_valid = 0, first = 0, last = 0, dark = 0, miso, in_ready, fflag, rflag, locked, busy;
    logic [39:0] in_data = '0, lanes;
    logic [9:0] sync, sq[$], lq[$];
    logic [1:0] fq[$];
    int err_total = 0, checks = 0;
    pixel_output_sync_framer i_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_link_clock(i_link_clock),
        .i_link_nrst(i_link_nrst), .i_spi_sck(sck), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(miso),
        .i_in_valid(in_valid), .o_in_ready(in_ready), .i_in_data(in_data), .i_in_first(first), .i_in_last(last),
        .i_in_dark(dark), .i_in_frame_start(1'b1), .i_in_frame_end(1'b1), .o_lane_data(lanes),
        .o_sync_lane(sync), .o_frame_flag(fflag), .o_row_flag(rflag));
    lane_receiver i_rx (.i_link_clock(i_link_clock), .i_link_nrst(i_link_nrst), .i_lane_data(lanes),
        .i_sync_lane(sync), .o_locked(locked), .o_busy(busy));
    initial forever #2 i_clock = ~i_clock;
    // odd offset keeps link edges clear of core edges
    initial begin
        #1.3;
        forever #7.5 i_link_clock = ~i_link_clock;
    end
    // sampled mid-period, away from the edge that launches the lanes
    always @(negedge i_link_clock) if (busy) begin
        sq.push_back(sync);
        lq.push_back(lanes[9:0]);
        fq.push_back({fflag, rflag});
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // reference row checksum, msb first over each lane word
    function automatic logic [9:0] crc(input logic [9:0] c, input logic [9:0] d);
        for (int i = 9; i >= 0; i--)
            c = {c[8:0], 1'b0} ^ ((c[9] ^ d[i]) ? CSUM_POLY : 10'h000);
        return c;
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic clk(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    task automatic spi(input logic [8:0] a, input logic rw, input logic [15:0] d, output logic [15:0] q);
        logic [25:0] f;
        f = {a, rw, d};
        cs_n <= 1'b0;
        for (int i = 25; i >= 0; i--) begin
            mosi <= f[i];
            clk(5);
            q = {q[14:0], miso};
            sck <= 1'b1;
            clk(5);
            sck <= 1'b0;
        end
        clk(5);
        cs_n <= 1'b1;
        clk(5);
    endtask
    task automatic test_idle();
        for (int i = 0; i < 4; i++) chk(16'(lanes[i*10 +: 10]), 16'h03a6);
        chk(16'(sync), 16'h03a6);
        chk(16'(locked), 16'h0001);
        $display("test_idle done");
    endtask
    task automatic test_regs();
        logic [15:0] q;
        for (int i = IDX_CAL; i <= IDX_ALIGN; i++) begin
            spi(DARK_CAL_CONFIG_ADDR + 9'(i), 1'b0, 16'h0000, q);
            chk(q, REG_RESET[i]);
        end
        spi(DARK_LEVEL_ERROR_STATUS_ADDR, 1'b1, 16'h00ff, q);
        spi(DARK_LEVEL_ERROR_STATUS_ADDR, 1'b0, 16'h0000, q);
        chk(q, 16'h0000);
        $display("test_regs done");
    endtask
    task automatic test_row(input logic [15:0] gen, input logic dk, input logic [9:0] sd, input logic [9:0] exp,
        input logic [1:0] fl);
        logic [15:0] q;
        logic r;
        int n;
        spi(OUTPUT_GENERAL_CONFIG_ADDR, 1'b1, gen, q);
        sq.delete();
        lq.delete();
        fq.delete();
        for (int w = 0; w < 2; w++) begin
            in_data <= {4{10'h100}};
            dark <= dk;
            first <= (w == 0);
            last <= (w == 1);
            in_valid <= 1'b1;
            n = 0;
            do begin
                @(negedge i_clock);
                r = in_ready;
                n++;
                @(posedge i_clock);
            end while (r !== 1'b1 && n < 50);
            if (r !== 1'b1) begin
                err_total++;
                results();
            end
        end
        in_valid <= 1'b0;
        clk(60);
        chk(16'(sq.size()), 16'h0005);
        chk(16'(sq[0]), 16'h032a);
        chk(16'(sq[1]), dk ? 16'h0015 : 16'h0035);
        chk(16'(sq[3]), 16'h02aa);
        chk(16'(sq[4]), 16'h0059);
        chk(16'(lq[2]), 16'(exp));
        chk(16'(lq[4]), 16'(crc(crc(sd, exp), exp)));
        chk(16'(fq[0]), 16'(fl & 2'b10));
        chk(16'(fq[1]), 16'(fl));
        $display("test_row done");
    endtask
    // dark row, auto mode, too few samples: manual offset ignored, flags gated, error raised
    task automatic test_dark();
        logic [15:0] q;
        spi(DARK_CAL_CONFIG_ADDR, 1'b1, 16'hc708, q);
        test_row(16'h000b, 1'b1, 10'h3ff, 10'h100, 2'b00);
        spi(DARK_LEVEL_ERROR_STATUS_ADDR, 1'b0, 16'h0000, q);
        chk(q, 16'h000f);
        $display("test_dark done");
    endtask
    initial begin
        clk(6);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_link_clock);
        i_link_nrst <= 1'b1;
        clk(20);
        test_idle();
        test_regs();
        test_row(16'hc00a, 1'b0, 10'h000, 10'h105, 2'b11);
        test_row(16'hc40a, 1'b0, 10'h000, 10'h0fb, 2'b11);
        test_row(16'he000, 1'b0, 10'h000, 10'h040, 2'b11);
        test_dark();
        results();
    end
    initial begin
        clk(20000);
        err_total++;
        results();
    end
endmodule
